//--- verilog/fpa_host.sv
// Host controller for flash identification and protection status reads
`timescale 1ns/1ps
module fpa_host
  import fpa_pkg::*;
#(
  parameter int WAIT_CYC = fpa_pkg::ACCESS_CYC
) (
  input  wire logic                      clock_i,     // System clock 100 MHz
  input  wire logic                      resetn_i,    // Sync reset, active low
  input  wire logic                      ce_i,        // Clock enable
  input  wire logic                      req_i,       // Start an operation
  input  wire fpa_pkg::fpa_op_e          op_i,        // Operation kind
  input  wire logic [1:0]                sel_i,       // Identification code select
  input  wire logic [fpa_pkg::SECT_W-1:0] sector_i,   // Sector for status read
  input  wire logic [fpa_pkg::ADDR_W-1:0] addr_i,     // Address for plain cycles
  input  wire logic [fpa_pkg::DATA_W-1:0] wdata_i,    // Data for plain writes
  input  wire logic                      unprot_i,    // Request temporary unprotect
  input  wire logic                      lockout_i,   // Supply below lockout_threshold
  input  wire logic [fpa_pkg::DATA_W-1:0] data_lines_i, // Data lines from device
  output logic [fpa_pkg::ADDR_W-1:0]     addr_o,      // Address pins
  output logic                           hv_a9_o,     // Bit 9 at high_voltage_level
  output logic                           hv_reset_o,  // Reset pin at high_voltage_level
  output logic                           reset_n_o,   // Device reset pin, low active
  output logic                           cs_n_o,      // Chip select
  output logic                           oe_n_o,      // Output enable
  output logic                           we_n_o,      // Write strobe
  output logic [fpa_pkg::DATA_W-1:0]     data_lines_o, // Data lines to device
  output logic                           data_lines_oe_o, // Host drives data lines
  output logic [fpa_pkg::DATA_W-1:0]     rdata_o,     // Result of last read
  output logic                           protected_o, // Last status read protected
  output logic                           busy_o,      // Operation in progress
  output logic                           done_o,      // Operation done pulse
  output logic                           refused_o    // Write refused pulse
);
  import fpa_pkg::*;

  initial begin
    if (ADDR_W != SECT_LSB + SECT_W) $error("address width mismatch");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_HV_SET, S_CYC, S_WAIT, S_FINISH
  } fpa_st_e;

  typedef struct packed {
    fpa_st_e            st;
    fpa_op_e            op;
    logic [2:0]         step;
    logic               start;
    logic               wr;
    logic [1:0]         sync_lk;
    logic [DATA_W-1:0]  dq_s1, dq_s2;
    logic [ADDR_W-1:0]  addr;
    logic [ADDR_W-1:0]  id_a;
    logic [DATA_W-1:0]  wdata;
    logic               hv_a9, hv_rst, rst_n;
    logic [DATA_W-1:0]  rdata;
    logic               prot, busy, done, refused;
  } fpa_host_s;

  fpa_host_s s_q, s_d;

  logic              cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic              cyc_oe;

  // Address for an identification read
  function automatic logic [ADDR_W-1:0] id_addr(input logic [1:0] sel,
                                                input logic [SECT_W-1:0] sec);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[SEL_LSB +: 2] = sel;
    a[A6_BIT] = 1'b0;
    a[SECT_LSB +: SECT_W] = sec;
    return a;
  endfunction

  // Command sequence for in-system identify, then read, then reset
  always_comb begin
    s_d = s_q;
    s_d.start   = 1'b0;
    s_d.done    = 1'b0;
    s_d.refused = 1'b0;
    s_d.sync_lk = {s_q.sync_lk[0], lockout_i};
    s_d.dq_s1   = data_lines_i;
    s_d.dq_s2   = s_q.dq_s1;
    s_d.hv_rst  = unprot_i && !s_q.sync_lk[1];
    case (s_q.st)
      S_IDLE: begin
        if (req_i) begin
          s_d.op = op_i;
          s_d.step = 3'h0;
          // Identification address held for the whole command sequence
          s_d.id_a = id_addr(sel_i, sector_i);
          if (op_i == OP_WRITE && s_q.sync_lk[1]) begin
            s_d.refused = 1'b1;
            s_d.done = 1'b1;
          end else begin
            s_d.busy = 1'b1;
            s_d.st = (op_i == OP_HV_READ) ? S_HV_SET : S_CYC;
            s_d.addr = (op_i == OP_HV_READ) ? id_addr(sel_i, sector_i) : addr_i;
            s_d.wdata = wdata_i;
            s_d.hv_a9 = (op_i == OP_HV_READ);
          end
        end
      end
      S_HV_SET: begin
        s_d.st = S_CYC;
      end
      S_CYC: begin
        s_d.start = 1'b1;
        s_d.st = S_WAIT;
        s_d.wr = 1'b0;
        if (s_q.op == OP_WRITE) s_d.wr = 1'b1;
        // Identify commands only; no unprotect cycle is ever issued
        if (s_q.op == OP_SYS_IDENT) begin
          case (s_q.step)
            3'h0: begin s_d.wr = 1'b1; s_d.addr = UNLK_ADDR1; s_d.wdata = UNLK_DATA1; end
            3'h1: begin s_d.wr = 1'b1; s_d.addr = UNLK_ADDR2; s_d.wdata = UNLK_DATA2; end
            3'h2: begin s_d.wr = 1'b1; s_d.addr = UNLK_ADDR1; s_d.wdata = CMD_IDENT; end
            3'h3: begin s_d.wr = 1'b0; s_d.addr = s_q.id_a; end
            default: begin s_d.wr = 1'b1; s_d.addr = '0; s_d.wdata = CMD_RESET; end
          endcase
        end
        // Lockout seen before a write: refuse, done and refused together
        if (s_q.sync_lk[1] && s_d.wr) begin
          s_d.start   = 1'b0;
          s_d.refused = 1'b1;
          s_d.done    = 1'b1;
          s_d.busy    = 1'b0;
          s_d.hv_a9   = 1'b0;
          s_d.st      = S_IDLE;
        end
      end
      S_WAIT: begin
        if (cyc_done) begin
          if (!s_q.wr) begin
            s_d.rdata = cyc_rdata;
            s_d.prot = (cyc_rdata == PROT_YES) && (s_q.addr[SEL_LSB +: 2] == SEL_PROT);
          end
          if (s_q.op == OP_SYS_IDENT && s_q.step != 3'h4) begin
            s_d.step = s_q.step + 3'h1;
            s_d.st = S_CYC;
          end else begin
            s_d.st = S_FINISH;
          end
        end
      end
      default: begin
        s_d.st = S_IDLE;
        s_d.busy = 1'b0;
        s_d.hv_a9 = 1'b0;
        s_d.done = 1'b1;
      end
    endcase
  end

  // State register; strobes stay inactive from reset
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s_q <= '{st: S_IDLE, op: OP_READ, step: 3'h0, start: 1'b0, wr: 1'b0,
               sync_lk: 2'h3, dq_s1: '0, dq_s2: '0, addr: '0, id_a: '0, wdata: '0,
               hv_a9: 1'b0, hv_rst: 1'b0, rst_n: 1'b1, rdata: '0,
               prot: 1'b0, busy: 1'b0, done: 1'b0, refused: 1'b0};
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // Pin cycle sequencer
  fpa_cycle #(
    .WAIT_CYC (WAIT_CYC)
  ) u_cycle (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .start_i  (s_q.start),
    .write_i  (s_q.wr),
    .dq_in_i  (s_q.dq_s2),
    .cs_n_o   (cs_n_o),
    .oe_n_o   (oe_n_o),
    .we_n_o   (we_n_o),
    .dq_oe_o  (cyc_oe),
    .rdata_o  (cyc_rdata),
    .done_o   (cyc_done)
  );

  // Outputs from registers
  assign addr_o          = s_q.addr;
  assign hv_a9_o         = s_q.hv_a9;
  assign hv_reset_o      = s_q.hv_rst;
  assign reset_n_o       = s_q.rst_n;
  assign data_lines_o    = s_q.wdata;
  assign data_lines_oe_o = cyc_oe;
  assign rdata_o         = s_q.rdata;
  assign protected_o     = s_q.prot;
  assign busy_o          = s_q.busy;
  assign done_o          = s_q.done;
  assign refused_o       = s_q.refused;

  // High-voltage read holds bit 6 low while bit 9 is raised
  property p_hv_addr;
    @(posedge clock_i) disable iff (!resetn_i)
      s_q.hv_a9 |-> !s_q.addr[A6_BIT];
  endproperty
  a_hv_addr: assert property (p_hv_addr) else $error("bit 6 high in hv read");

  // No write strobe while supply is in lockout
  property p_no_write_lockout;
    @(posedge clock_i) disable iff (!resetn_i)
      (ce_i && s_d.start && s_d.wr) |-> !s_q.sync_lk[1];
  endproperty
  a_no_write_lockout: assert property (p_no_write_lockout) else $error("write in lockout");

  // Second unlock write (step 1) carries the second unlock address and data
  sequence s_unlock2;
    s_q.start && s_q.op == OP_SYS_IDENT && s_q.step == 3'h1;
  endsequence
  property p_unlock_order;
    @(posedge clock_i) disable iff (!resetn_i)
      s_unlock2 |->
        s_q.addr == UNLK_ADDR2 && s_q.wdata == UNLK_DATA2;
  endproperty
  a_unlock_order: assert property (p_unlock_order) else $error("unlock order wrong");

  // Temporary unprotect dropped one cycle after request falls
  property p_unprot_drop;
    @(posedge clock_i) disable iff (!resetn_i)
      (ce_i && !unprot_i) |=> !s_q.hv_rst;
  endproperty
  a_unprot_drop: assert property (p_unprot_drop) else $error("hv reset stuck");

  // Output enable never low while write strobe low
  property p_logic_inhibit;
    @(posedge clock_i) disable iff (!resetn_i)
      !we_n_o |-> oe_n_o && !cs_n_o;
  endproperty
  a_logic_inhibit: assert property (p_logic_inhibit) else $error("write while inhibited");
endmodule // fpa_host

//--- verilog/fpa_pkg.sv
// Package with constants for the flash protection and identification host
package fpa_pkg;
  // Pin widths
  localparam int ADDR_W     = 21;
  localparam int DATA_W     = 8;
  // Address field positions
  localparam int SEL_LSB    = 0;     // Code select bits 1:0
  localparam int HV_ADDR    = 9;     // Address bit raised to high voltage
  localparam int A6_BIT     = 6;     // Must be low for high-voltage read
  localparam int SECT_LSB   = 13;    // Sector address low bit
  localparam int SECT_W     = 8;     // Sector address bits 20:13
  // Code select values
  localparam logic [1:0] SEL_MAKER = 2'h0;
  localparam logic [1:0] SEL_PART  = 2'h1;
  localparam logic [1:0] SEL_PROT  = 2'h2;
  // Protection status values
  localparam logic [7:0] PROT_YES  = 8'h01;
  localparam logic [7:0] PROT_NO   = 8'h00;
  // In-system command cycles (unlock pair, identify command and reset command)
  localparam logic [20:0] UNLK_ADDR1 = 21'h000aaa;
  localparam logic [20:0] UNLK_ADDR2 = 21'h000555;
  localparam logic [7:0]  UNLK_DATA1 = 8'haa;
  localparam logic [7:0]  UNLK_DATA2 = 8'h55;
  localparam logic [7:0]  CMD_IDENT  = 8'h90;
  localparam logic [7:0]  CMD_RESET  = 8'hf0;
  // Bus timing
  localparam int CLK_NS       = 10;
  localparam int STROBE_NS    = 40;  // Least strobe low time
  localparam int SETUP_NS     = 20;  // Least setup before strobe / read access
  localparam int ACCESS_NS    = 70;  // Read access time
  localparam int GLITCH_NS    = 5;   // Pulses below this are not writes
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  // Operations
  typedef enum logic [1:0] {
    OP_HV_READ,   // High-voltage identification read
    OP_SYS_IDENT, // In-system identification read
    OP_WRITE,     // Plain bus write cycle
    OP_READ       // Plain bus read cycle
  } fpa_op_e;
endpackage : fpa_pkg

//--- verilog/fpa_cycle.sv
// One bus cycle sequencer for the flash pins
`timescale 1ns/1ps
module fpa_cycle
  import fpa_pkg::*;
#(
  parameter int WAIT_CYC = fpa_pkg::ACCESS_CYC
) (
  input  wire logic              clock_i,   // System clock
  input  wire logic              resetn_i,  // Sync reset, active low
  input  wire logic              ce_i,      // Clock enable
  input  wire logic              start_i,   // Start a cycle
  input  wire logic              write_i,   // 1 write, 0 read
  input  wire logic [DATA_W-1:0] dq_in_i,   // Synchronised data lines
  output logic                   cs_n_o,    // Chip select, low active
  output logic                   oe_n_o,    // Output enable, low active
  output logic                   we_n_o,    // Write strobe, low active
  output logic                   dq_oe_o,   // Host drives data lines
  output logic [DATA_W-1:0]      rdata_o,   // Captured read data
  output logic                   done_o     // Cycle finished pulse
);
  import fpa_pkg::*;

  initial begin
    if (WAIT_CYC < 3 || WAIT_CYC > 255) $error("WAIT_CYC out of range");
  end

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fpa_cst_e;
  typedef struct packed {
    fpa_cst_e           st;
    logic [7:0]         cnt;
    logic               wr;
    logic               cs_n, oe_n, we_n, dq_oe, done;
    logic [DATA_W-1:0]  rdata;
  } fpa_cyc_s;

  fpa_cyc_s s_q, s_d;

  // Cycle sequencing: setup, strobe low, release
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      C_IDLE: begin
        if (start_i) begin
          s_d.st    = C_SETUP;
          s_d.wr    = write_i;
          s_d.cnt   = 8'(SETUP_CYC);
          s_d.cs_n  = 1'b0;
          s_d.oe_n  = 1'b1;
          s_d.dq_oe = write_i;
        end
      end
      C_SETUP: begin
        if (s_q.cnt <= 8'h01) begin
          s_d.st  = C_STROBE;
          s_d.cnt = s_q.wr ? 8'(STROBE_CYC) : 8'(WAIT_CYC);
          if (s_q.wr) s_d.we_n = 1'b0;
          else s_d.oe_n = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      C_STROBE: begin
        if (s_q.cnt <= 8'h01) begin
          s_d.st = C_HOLD;
          s_d.we_n = 1'b1;
          if (!s_q.wr) s_d.rdata = dq_in_i;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      default: begin
        s_d.st    = C_IDLE;
        s_d.cs_n  = 1'b1;
        s_d.oe_n  = 1'b1;
        s_d.dq_oe = 1'b0;
        s_d.done  = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s_q <= '{st: C_IDLE, cnt: 8'h00, wr: 1'b0, cs_n: 1'b1, oe_n: 1'b1,
               we_n: 1'b1, dq_oe: 1'b0, done: 1'b0, rdata: '0};
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign cs_n_o  = s_q.cs_n;
  assign oe_n_o  = s_q.oe_n;
  assign we_n_o  = s_q.we_n;
  assign dq_oe_o = s_q.dq_oe;
  assign rdata_o = s_q.rdata;
  assign done_o  = s_q.done;

  // Write strobe low only with chip select low and output enable high
  property p_write_legal;
    @(posedge clock_i) disable iff (!resetn_i)
      !s_q.we_n |-> (!s_q.cs_n && s_q.oe_n);
  endproperty
  a_write_legal: assert property (p_write_legal) else $error("bad write strobe");

  // Write strobe stays low long enough to beat the glitch filter
  property p_we_width;
    @(posedge clock_i) disable iff (!resetn_i)
      (ce_i && $fell(s_q.we_n)) |-> !s_q.we_n [*2];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe too short");

  // Chip select falls before write strobe so address is stable first
  property p_cs_first;
    @(posedge clock_i) disable iff (!resetn_i)
      $fell(s_q.we_n) |-> $past(!s_q.cs_n);
  endproperty
  a_cs_first: assert property (p_cs_first) else $error("strobe before select");
endmodule // fpa_cycle

//--- bench/fpa_dev_model.sv
// Behavioural model of the flash device identification and protection pins
`timescale 1ns/1ps
module fpa_dev_model
  import fpa_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3a, // Arbitrary maker code
  parameter logic [7:0] PART_ID  = 8'h6e, // Arbitrary part code
  parameter int         ACC_NS   = 30     // Read access delay
) (
  input  wire logic [ADDR_W-1:0] addr_i,     // Address pins
  input  wire logic              hv_a9_i,    // Bit 9 at high voltage
  input  wire logic              hv_reset_i, // Reset pin at high voltage
  input  wire logic              reset_n_i,  // Reset pin, low active
  input  wire logic              cs_n_i,     // Chip select
  input  wire logic              oe_n_i,     // Output enable
  input  wire logic              we_n_i,     // Write strobe
  input  wire logic              vlow_i,     // Supply below lockout
  input  wire logic [7:0]        dq_i,       // Resolved data lines
  output logic      [7:0]        dq_o        // Device side of data lines
);
  logic [255:0]      prot_q = '0;
  logic [1:0]        st_q   = 2'h0;
  logic              armed_q = 1'b0;
  logic [ADDR_W-1:0] wa_q;
  realtime           t_lo = 0;
  int                wr_cnt = 0;
  logic              drive;
  wire logic         rd_ok;
  logic [7:0]        rd_val;
  logic [7:0]        last_q = 8'h00;
  logic [255:0]      eff;

  // Command sequencer, unlock pair then identify; reset command leaves it
  function automatic logic [1:0] next_st(logic [1:0] s, logic [ADDR_W-1:0] a, logic [7:0] d);
    if (s == 2'h3) return (d == CMD_RESET) ? 2'h0 : 2'h3;
    if (s == 2'h1 && a == UNLK_ADDR2 && d == UNLK_DATA2) return 2'h2;
    if (s == 2'h2 && a == UNLK_ADDR1 && d == CMD_IDENT) return 2'h3;
    if (a == UNLK_ADDR1 && d == UNLK_DATA1) return 2'h1;
    return 2'h0;
  endfunction

  // High voltage on reset lifts protection only while it stands
  assign eff = hv_reset_i ? '0 : prot_q;
  // Strobes seen idle once after power-up before writes count
  always @(cs_n_i or we_n_i) if (cs_n_i && we_n_i) armed_q = 1'b1;
  // Low supply or reset pin low returns to array read
  always @(vlow_i or reset_n_i) if (vlow_i || !reset_n_i) st_q = 2'h0;
  // Address on the later falling strobe
  always @(negedge cs_n_i or negedge we_n_i) begin
    if (!cs_n_i && !we_n_i) begin
      wa_q = addr_i;
      t_lo = $realtime;
    end
  end
  // Data on the earlier rising strobe, with logical, glitch and supply gates
  always @(posedge cs_n_i or posedge we_n_i) begin
    if ((cs_n_i ^ we_n_i) && oe_n_i && armed_q && !vlow_i && reset_n_i
        && ($realtime - t_lo >= GLITCH_NS)) begin
      wr_cnt++;
      st_q = next_st(st_q, wa_q, dq_i);
    end
  end
  // Read value: codes in identification, array pattern otherwise
  assign drive = !cs_n_i && !oe_n_i && we_n_i && reset_n_i;
  assign #(ACC_NS) rd_ok = drive;
  always_comb begin
    rd_val = addr_i[7:0] ^ addr_i[20:13] ^ 8'h3c;
    if (st_q == 2'h3 || (hv_a9_i && !addr_i[A6_BIT])) begin
      case (addr_i[1:0])
        2'h0: rd_val = MAKER_ID;
        2'h1: rd_val = PART_ID;
        default: rd_val = eff[addr_i[20:13]] ? PROT_YES : PROT_NO;
      endcase
    end
  end
  // Released lines show the inverse of the last driven value
  always @(rd_val or drive or rd_ok) if (drive && rd_ok) last_q = rd_val;
  assign dq_o = (drive && rd_ok) ? rd_val : ~last_q;
endmodule // fpa_dev_model

//--- bench/tb_fpa_host.sv
// Self-checking bench for the flash identification host
`timescale 1ns/1ps
module tb_fpa_host;
  import fpa_pkg::*;
  localparam logic [7:0] MK = 8'h3a; // Arbitrary maker code
  localparam logic [7:0] PT = 8'h6e; // Arbitrary part code
  logic clock_i, resetn_i, ce_i, req_i, unprot_i, lockout_i, ce_rnd, g_pr, g_rf;
  logic hv_a9_o, hv_reset_o, reset_n_o, cs_n_o, oe_n_o, we_n_o, data_lines_oe_o;
  logic protected_o, busy_o, done_o, refused_o;
  fpa_op_e     op_i;
  logic [1:0]  sel_i, s;
  logic [7:0]  sector_i, wdata_i, data_lines_i, data_lines_o, rdata_o, dev_dq, sec, g_rd;
  logic [20:0] addr_i, addr_o, a;
  logic [255:0] prot_tb;
  logic [31:0] seed;
  int          failures, comparisons, w0;
  realtime     t_we;

  fpa_host #(.WAIT_CYC(7)) i_dut (.clock_i, .resetn_i, .ce_i, .req_i, .op_i, .sel_i,
    .sector_i, .addr_i, .wdata_i, .unprot_i, .lockout_i, .data_lines_i, .addr_o,
    .hv_a9_o, .hv_reset_o, .reset_n_o, .cs_n_o, .oe_n_o, .we_n_o, .data_lines_o,
    .data_lines_oe_o, .rdata_o, .protected_o, .busy_o, .done_o, .refused_o);
  fpa_dev_model #(.MAKER_ID(MK), .PART_ID(PT)) i_dev (.addr_i(addr_o), .hv_a9_i(hv_a9_o),
    .hv_reset_i(hv_reset_o), .reset_n_i(reset_n_o), .cs_n_i(cs_n_o), .oe_n_i(oe_n_o),
    .we_n_i(we_n_o), .vlow_i(lockout_i), .dq_i(data_lines_i), .dq_o(dev_dq));
  // Data lines resolved from both drivers
  assign data_lines_i = data_lines_oe_o ? data_lines_o : dev_dq;

  // Clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Clock enable, random while ce_rnd is set
  always @(negedge clock_i) ce_i <= ce_rnd ? xs() % 4 != 0 : 1'b1;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_id(logic [1:0] c, logic [7:0] n);
    if (c == 2'h0) return MK;
    if (c == 2'h1) return PT;
    return (prot_tb[n] && !unprot_i) ? 8'h01 : 8'h00;
  endfunction
  function automatic logic [7:0] exp_arr(logic [20:0] x);
    return x[7:0] ^ x[20:13] ^ 8'h3c;
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One operation, request held until taken, result kept at done
  task automatic run(fpa_op_e op, logic [1:0] c, logic [7:0] n, logic [20:0] x);
    int k;
    @(negedge clock_i);
    while (done_o === 1'b1) @(negedge clock_i);
    op_i = op;
    sel_i = c;
    sector_i = n;
    addr_i = x;
    wdata_i = xs();
    req_i = 1'b1;
    k = 0;
    while (done_o !== 1'b1 && k < 400) begin
      @(negedge clock_i);
      if (busy_o === 1'b1) req_i = 1'b0;
      k++;
    end
    req_i = 1'b0;
    if (k >= 400) check("done", 0, 1);
    g_rd = rdata_o;
    g_pr = protected_o;
    g_rf = refused_o;
  endtask

  // Shape of every write strobe and high-voltage read
  always @(negedge we_n_o) begin
    t_we = $realtime;
    if (resetn_i === 1'b1) check("wr_pins", {cs_n_o, oe_n_o, data_lines_oe_o}, 3'b011);
  end
  always @(posedge we_n_o) if (resetn_i === 1'b1) check("wr_len", $realtime - t_we >= STROBE_NS, 1);
  always @(negedge oe_n_o) if (hv_a9_o === 1'b1) check("hv_addr",
    {addr_o[A6_BIT], we_n_o, addr_o[1:0], addr_o[20:13]}, {2'b01, sel_i, sector_i});

  // Watchdog
  initial begin
    #400000;
    failures++;
    complete_run();
  end

  initial begin
    seed = 68;
    {failures, comparisons} = '0;
    {resetn_i, req_i, unprot_i, lockout_i, ce_rnd} = '0;
    {sel_i, sector_i, addr_i, wdata_i} = '0;
    ce_i = 1'b1;
    op_i = OP_READ;
    prot_tb = '0;
    repeat (6) @(negedge clock_i);
    resetn_i = 1'b1;
    @(negedge clock_i);
    check("idle", {cs_n_o, oe_n_o, we_n_o, data_lines_oe_o, busy_o, hv_a9_o, hv_reset_o,
      reset_n_o}, 8'he1);
    run(OP_HV_READ, 2'h2, 8'h05, 0);
    check("fresh", g_rd, 8'h00);
    for (int i = 0; i < 256; i++) prot_tb[i] = xs() % 3 == 0;
    prot_tb[8'h10] = 1'b1;
    i_dev.prot_q = prot_tb;
    // Identification codes by both methods
    for (int i = 0; i < 24; i++) begin
      s = i % 3;
      sec = (i == 23) ? 8'hff : xs();
      run(i[0] ? OP_SYS_IDENT : OP_HV_READ, s, sec, 0);
      check("id", g_rd, exp_id(s, sec));
      check("prot", g_pr, s == 2 && exp_id(s, sec) == 8'h01);
    end
    // Plain cycles with a stuttering clock enable
    ce_rnd = 1'b1;
    for (int i = 0; i < 30; i++) begin
      a = xs();
      w0 = i_dev.wr_cnt;
      run(i[0] ? OP_WRITE : OP_READ, 0, 0, a);
      if (i[0]) check("wcnt", i_dev.wr_cnt - w0, 1);
      else check("arr", g_rd, exp_arr(a));
    end
    ce_rnd = 1'b0;
    // Temporary unprotect and restore
    unprot_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check("hv_rst", hv_reset_o, 1);
    run(OP_HV_READ, 2'h2, 8'h10, 0);
    check("tmp", g_rd, 8'h00);
    unprot_i = 1'b0;
    repeat (4) @(negedge clock_i);
    run(OP_SYS_IDENT, 2'h2, 8'h10, 0);
    check("back", g_rd, 8'h01);
    // Low supply lockout refuses writes and high voltage on the reset pin
    lockout_i = 1'b1;
    unprot_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check("hv_lko", hv_reset_o, 0);
    for (int k = 0; k < 2; k++) begin
      w0 = i_dev.wr_cnt;
      run(k ? OP_SYS_IDENT : OP_WRITE, 0, 0, 21'h001234);
      check("refused", g_rf, 1);
      check("no_wr", i_dev.wr_cnt - w0, 0);
    end
    {lockout_i, unprot_i} = 2'b00;
    repeat (4) @(negedge clock_i);
    w0 = i_dev.wr_cnt;
    run(OP_WRITE, 0, 0, 21'h001234);
    check("ok_wr", {g_rf, 8'(i_dev.wr_cnt - w0)}, 9'h001);
    complete_run();
  end
endmodule // tb_fpa_host
